// >>> hdl/ddc_pkg.sv
// Purpose: constants for the datapath control register block
// Assumes: Avalon-MM slave, 32-bit data, byte addressed, 25 MHz clock
// Notes: one 16-bit control register plus a read-only sync status word
// Contract
// - Bit 15 enables first pair offset fix
// - Bit 14 enables second pair offset fix
// - Bit 13 enables first pair gain/phase fix
// - Bit 12 enables second pair gain/phase fix
// - Bits 11:8 one-hot select interpolation factor
// - Bit 7 enables FIFO, set after reset
// - Bit 4 drives fault pin, else high-Z
// - Bit 3 sets fault pin polarity
// - Bit 2 syncs FIFO output pointer
// - Sync with bit 2 aligns divided clocks
// - Bit 1 enables first pair droop filter
// - Bit 0 enables second pair droop filter
// - Reset value of control register is 0x049C
package ddc_pkg;
    localparam logic [3:0]  DDC_ADDR_W      = 4'h4;
    localparam logic [3:0]  DDC_CTRL_OFS    = 4'h0;
    localparam logic [3:0]  DDC_STAT_OFS    = 4'h4;
    localparam logic [15:0] DDC_CTRL_RST    = 16'h049C;
    localparam logic [15:0] DDC_CTRL_WMASK  = 16'hFF9F;
    localparam int          DDC_B_OFS_A     = 15;
    localparam int          DDC_B_OFS_B     = 14;
    localparam int          DDC_B_GP_A      = 13;
    localparam int          DDC_B_GP_B      = 12;
    localparam int          DDC_B_INTERP_HI = 11;
    localparam int          DDC_B_INTERP_LO = 8;
    localparam int          DDC_B_FIFO      = 7;
    localparam int          DDC_B_FOE       = 4;
    localparam int          DDC_B_FPOL      = 3;
    localparam int          DDC_B_SYNC      = 2;
    localparam int          DDC_B_DROOP_A   = 1;
    localparam int          DDC_B_DROOP_B   = 0;
    localparam logic [3:0]  DDC_IF_1X       = 4'h0;
    localparam logic [3:0]  DDC_IF_2X       = 4'h1;
    localparam logic [3:0]  DDC_IF_4X       = 4'h2;
    localparam logic [3:0]  DDC_IF_8X       = 4'h4;
    localparam logic [3:0]  DDC_IF_16X      = 4'h8;
    localparam logic [4:0]  DDC_RATE_RST    = 5'h08;
    localparam logic [3:0]  DDC_DIV_RST     = 4'h0;
endpackage : ddc_pkg

// >>> hdl/ddc_sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock domain on the output side
// Notes: first stage read only by the second stage
module ddc_sync2
    import ddc_pkg::*;
(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic d,
    output logic      q
);
    typedef struct packed
    {
        logic s1;
        logic s2;
    } ddc_sync_t;

    ddc_sync_t st_q;
    ddc_sync_t st_d;

    always_comb
    begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign q = st_q.s2;
endmodule : ddc_sync2

// >>> hdl/ddc_top.sv
// Purpose: datapath control register with Avalon-MM access
// Assumes: one access answered per idle cycle; waitrequest high one cycle
// Notes: fault pin is open as two signals; sync arrives on a pin
module ddc_top
    import ddc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        alarm_event,
    input  wire logic        sync_pin,
    output logic             first_pair_offset_fix_en,
    output logic             second_pair_offset_fix_en,
    output logic             first_pair_gain_phase_fix_en,
    output logic             second_pair_gain_phase_fix_en,
    output logic [4:0]       interp_rate_onehot,
    output logic             fifo_en,
    output logic             fifo_ptr_sync,
    output logic             clkdiv_align,
    output logic             first_pair_droop_comp_en,
    output logic             second_pair_droop_comp_en,
    output logic             fault_o,
    output logic             fault_oe
);
    typedef struct packed
    {
        logic [15:0] ctrl;
        logic        ack;
        logic [31:0] rdata;
        logic        ofs_a;
        logic        ofs_b;
        logic        gp_a;
        logic        gp_b;
        logic [4:0]  rate;
        logic        fifo;
        logic        psync;
        logic        align;
        logic        drp_a;
        logic        drp_b;
        logic        fo;
        logic        foe;
        logic        sync_d1;
        logic [3:0]  div;
        logic [7:0]  sync_cnt;
    } ddc_state_t;

    ddc_state_t st_q;
    ddc_state_t st_d;
    logic       sync_s;
    logic       alarm_s;
    logic       sync_rise;
    logic       req;

    ddc_sync2 u_sync
    (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (sync_pin),
        .q      (sync_s)
    );

    ddc_sync2 u_alarm
    (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (alarm_event),
        .q      (alarm_s)
    );

    assign req       = (read || write) && !st_q.ack;
    assign sync_rise = sync_s && !st_q.sync_d1;

    always_comb
    begin
        st_d         = st_q;
        st_d.ack     = req;
        st_d.sync_d1 = sync_s;
        // Bus access; a held request is served once, then released
        if (req && write && address == DDC_CTRL_OFS)
        begin
            if (byteenable[0])
                st_d.ctrl[7:0] = writedata[7:0] & DDC_CTRL_WMASK[7:0];
            if (byteenable[1])
                st_d.ctrl[15:8] = writedata[15:8];
        end
        if (req && read)
        begin
            if (address == DDC_CTRL_OFS)
                st_d.rdata = {16'h0000, st_q.ctrl};
            else if (address == DDC_STAT_OFS)
                st_d.rdata = {16'h0000, st_q.sync_cnt, st_q.div, 3'h0, alarm_s};
            else
                st_d.rdata = 32'h0000_0000;
        end
        st_d.ofs_a = st_q.ctrl[DDC_B_OFS_A];
        st_d.ofs_b = st_q.ctrl[DDC_B_OFS_B];
        st_d.gp_a  = st_q.ctrl[DDC_B_GP_A];
        st_d.gp_b  = st_q.ctrl[DDC_B_GP_B];
        // interpolation decode; undefined codes fall back to 1x
        case (st_q.ctrl[DDC_B_INTERP_HI:DDC_B_INTERP_LO])
            DDC_IF_2X:  st_d.rate = 5'h02;
            DDC_IF_4X:  st_d.rate = 5'h04;
            DDC_IF_8X:  st_d.rate = 5'h08;
            DDC_IF_16X: st_d.rate = 5'h10;
            default:    st_d.rate = 5'h01;
        endcase
        st_d.fifo  = st_q.ctrl[DDC_B_FIFO];
        st_d.psync = sync_rise && st_q.ctrl[DDC_B_SYNC];
        // divider restarts at zero so all phases line up
        st_d.align = sync_rise && st_q.ctrl[DDC_B_SYNC];
        if (sync_rise && st_q.ctrl[DDC_B_SYNC])
        begin
            st_d.div      = DDC_DIV_RST;
            st_d.sync_cnt = st_q.sync_cnt + 8'h01;
        end
        else
            st_d.div = st_q.div + 4'h1;
        st_d.drp_a = st_q.ctrl[DDC_B_DROOP_A];
        st_d.drp_b = st_q.ctrl[DDC_B_DROOP_B];
        // drive or release the fault pin
        st_d.foe   = st_q.ctrl[DDC_B_FOE];
        // polarity: low-active when bit is clear
        st_d.fo    = st_q.ctrl[DDC_B_FPOL] ? alarm_s : !alarm_s;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q      <= '0;
            st_q.ctrl <= DDC_CTRL_RST;
            st_q.rate <= DDC_RATE_RST;
            st_q.fifo <= 1'b1;
            st_q.foe  <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    // Waitrequest high until the answer is ready the next cycle
    assign waitrequest                   = !st_q.ack;
    assign readdata                      = st_q.rdata;
    assign first_pair_offset_fix_en      = st_q.ofs_a;
    assign second_pair_offset_fix_en     = st_q.ofs_b;
    assign first_pair_gain_phase_fix_en  = st_q.gp_a;
    assign second_pair_gain_phase_fix_en = st_q.gp_b;
    assign interp_rate_onehot            = st_q.rate;
    assign fifo_en                       = st_q.fifo;
    assign fifo_ptr_sync                 = st_q.psync;
    assign clkdiv_align                  = st_q.align;
    assign first_pair_droop_comp_en      = st_q.drp_a;
    assign second_pair_droop_comp_en     = st_q.drp_b;
    assign fault_o                       = st_q.fo;
    assign fault_oe                      = st_q.foe;

    AST_OFS_A: assert property (@(posedge clock) disable iff (!arst_n)
        1'b1 |=> first_pair_offset_fix_en == $past(st_q.ctrl[DDC_B_OFS_A]))
        else $error("offset A enable mismatch");
    AST_OFS_B: assert property (@(posedge clock) disable iff (!arst_n)
        1'b1 |=> second_pair_offset_fix_en == $past(st_q.ctrl[DDC_B_OFS_B]))
        else $error("offset B enable mismatch");
    AST_GP: assert property (@(posedge clock) disable iff (!arst_n)
        ##1 {first_pair_gain_phase_fix_en, second_pair_gain_phase_fix_en}
            == $past(st_q.ctrl[DDC_B_GP_A:DDC_B_GP_B]))
        else $error("gain/phase enables mismatch");
    AST_RATE: assert property (@(posedge clock) disable iff (!arst_n)
        $past(st_q.ctrl[11:8]) == DDC_IF_16X |-> interp_rate_onehot == 5'h10)
        else $error("16x not selected");
    AST_FIFO: assert property (@(posedge clock) disable iff (!arst_n)
        (req && write && address == DDC_CTRL_OFS && byteenable[0] && !writedata[7])
        |=> ##1 !fifo_en)
        else $error("fifo not disabled");
    AST_FOE: assert property (@(posedge clock) disable iff (!arst_n)
        fault_oe == $past(st_q.ctrl[DDC_B_FOE]))
        else $error("fault enable mismatch");
    AST_POL: assert property (@(posedge clock) disable iff (!arst_n)
        ##1 fault_o == ($past(st_q.ctrl[DDC_B_FPOL]) ~^ $past(alarm_s)))
        else $error("fault polarity wrong");
    AST_SYNC: assert property (@(posedge clock) disable iff (!arst_n)
        (sync_rise && st_q.ctrl[DDC_B_SYNC]) |=> fifo_ptr_sync && clkdiv_align)
        else $error("sync pulse missing");
    AST_ALIGN: assert property (@(posedge clock) disable iff (!arst_n)
        clkdiv_align |-> st_q.div == 4'h0 ##1 st_q.div == 4'h1)
        else $error("divider not aligned");
    AST_NOSYNC: assert property (@(posedge clock) disable iff (!arst_n)
        !$past(st_q.ctrl[DDC_B_SYNC]) |-> !fifo_ptr_sync)
        else $error("sync while disabled");
    AST_DROOP: assert property (@(posedge clock) disable iff (!arst_n)
        ##1 {first_pair_droop_comp_en, second_pair_droop_comp_en}
            == $past(st_q.ctrl[1:0]))
        else $error("droop enables mismatch");
    AST_RST: assert property (@(posedge clock)
        $rose(arst_n) |-> st_q.ctrl == DDC_CTRL_RST)
        else $error("reset value wrong");

    COV_WR: cover property (@(posedge clock) disable iff (!arst_n)
        req && write && address == DDC_CTRL_OFS);
    COV_RD: cover property (@(posedge clock) disable iff (!arst_n)
        req && read && address == DDC_STAT_OFS);
    COV_SYNC: cover property (@(posedge clock) disable iff (!arst_n) clkdiv_align);
    COV_HIZ: cover property (@(posedge clock) disable iff (!arst_n) !fault_oe);

    // Alarm shown on a driven pin
    COV_ALARM: cover property (@(posedge clock) disable iff (!arst_n) fault_oe && fault_o);

    AST_GP_B: assert property (@(posedge clock) disable iff (!arst_n)
        second_pair_gain_phase_fix_en == $past(st_q.ctrl[DDC_B_GP_B]))
        else $error("gain/phase B enable mismatch");

    AST_DROOP_B: assert property (@(posedge clock) disable iff (!arst_n)
        second_pair_droop_comp_en == $past(st_q.ctrl[DDC_B_DROOP_B]))
        else $error("droop B enable mismatch");

    AST_RSVD: assert property (@(posedge clock) disable iff (!arst_n)
        st_q.ctrl[6:5] == 2'b00)
        else $error("reserved bits set");

    AST_ONEHOT: assert property (@(posedge clock) disable iff (!arst_n)
        $onehot(interp_rate_onehot))
        else $error("rate not one-hot");

    AST_RATE8: assert property (@(posedge clock) disable iff (!arst_n)
        $past(st_q.ctrl[11:8]) == DDC_IF_8X |-> interp_rate_onehot == 5'h08)
        else $error("8x not selected");

    AST_RATE1: assert property (@(posedge clock) disable iff (!arst_n)
        $past(st_q.ctrl[11:8]) == DDC_IF_1X |-> interp_rate_onehot == 5'h01)
        else $error("1x not selected");

    // Answer lasts one cycle so a held strobe is not served twice
    AST_WAIT: assert property (@(posedge clock) disable iff (!arst_n)
        !waitrequest |=> waitrequest)
        else $error("waitrequest low too long");

    // pointer sync is a single pulse
    AST_PSYNC_ONE: assert property (@(posedge clock) disable iff (!arst_n)
        fifo_ptr_sync |=> !fifo_ptr_sync)
        else $error("pointer sync too long");

    AST_FIFO_ON: assert property (@(posedge clock) disable iff (!arst_n)
        $past(st_q.ctrl[DDC_B_FIFO]) |-> fifo_en)
        else $error("fifo not enabled");

    AST_HIZ: assert property (@(posedge clock) disable iff (!arst_n)
        !$past(st_q.ctrl[DDC_B_FOE]) |-> !fault_oe)
        else $error("fault pin not released");
endmodule : ddc_top

// >>> dv/tb.sv
// Purpose: self-checking bench for the datapath control register block
// Assumes: Avalon-MM slave answers by waitrequest low; outputs lag ctrl by one cycle
// Notes: fault pin checked only through fault_o and fault_oe
module tb;
    import ddc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, arst_n, read, write, alarm_event, sync_pin;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata, rq;
    logic        waitrequest, o_ofa, o_ofb, o_gpa, o_gpb, fifo_en, fifo_ptr_sync, clkdiv_align;
    logic        o_dra, o_drb, fault_o, fault_oe;
    logic [4:0]  interp_rate_onehot;
    int          errors, checks_done, cyc;
    ddc_top uut (.clock(clock), .arst_n(arst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .alarm_event(alarm_event), .sync_pin(sync_pin),
        .first_pair_offset_fix_en(o_ofa), .second_pair_offset_fix_en(o_ofb),
        .first_pair_gain_phase_fix_en(o_gpa), .second_pair_gain_phase_fix_en(o_gpb),
        .interp_rate_onehot(interp_rate_onehot), .fifo_en(fifo_en),
        .fifo_ptr_sync(fifo_ptr_sync), .clkdiv_align(clkdiv_align),
        .first_pair_droop_comp_en(o_dra), .second_pair_droop_comp_en(o_drb),
        .fault_o(fault_o), .fault_oe(fault_oe));
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic tally_and_finish;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge clock);
        read       <= ~wr;
        write      <= wr;
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        // Look mid-cycle so the edge that launches waitrequest is never raced
        @(negedge clock);
        while (waitrequest !== 1'b0)
            @(negedge clock);
        q = readdata;
        // Request stands until the edge at which waitrequest is sampled low
        @(posedge clock);
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic wr_ctrl(input logic [15:0] v, input logic [3:0] be);
        bus(1'b1, DDC_CTRL_OFS, {16'h0000, v}, be, rq);
        repeat (2) @(posedge clock);
        #1;
    endtask : wr_ctrl
    // Expected control outputs worked out from a register value
    function automatic logic [31:0] exp_outs(input logic [15:0] c);
        logic [4:0] r;
        case (c[11:8])
            4'h1: r = 5'h02;
            4'h2: r = 5'h04;
            4'h4: r = 5'h08;
            4'h8: r = 5'h10;
            default: r = 5'h01;
        endcase
        return {19'h00000, c[15:12], c[1:0], c[7], r};
    endfunction : exp_outs
    function automatic logic [31:0] outs();
        return {19'h00000, o_ofa, o_ofb, o_gpa, o_gpb, o_dra, o_drb, fifo_en, interp_rate_onehot};
    endfunction : outs
    task automatic t_reset;
        bus(1'b0, DDC_CTRL_OFS, 32'h0, 4'hF, rq);
        chk(rq, 32'h0000049C, "reset value");
        chk(outs(), exp_outs(16'h049C), "reset outputs");
        chk({31'h0, fault_oe}, 32'h1, "reset fault oe");
    endtask : t_reset
    task automatic t_fields;
        logic [15:0] v [8] = '{16'hF003, 16'h8102, 16'h4201, 16'h2480, 16'h1810,
                               16'h0300, 16'h0060, 16'h0F00};
        foreach (v[i])
        begin
            wr_ctrl(v[i], 4'hF);
            bus(1'b0, DDC_CTRL_OFS, 32'h0, 4'hF, rq);
            chk(rq, {16'h0000, v[i] & 16'hFF9F}, "readback");
            chk(outs(), exp_outs(v[i]), "field outputs");
        end
        wr_ctrl(16'hFFFF, 4'h2);
        bus(1'b0, DDC_CTRL_OFS, 32'h0, 4'hF, rq);
        chk(rq, 32'h0000FF00, "upper lane only");
        bus(1'b1, 4'hC, 32'h0000FFFF, 4'hF, rq);
        bus(1'b0, 4'hC, 32'h0, 4'hF, rq);
        chk(rq, 32'h0, "unmapped read");
        bus(1'b0, DDC_CTRL_OFS, 32'h0, 4'hF, rq);
        chk(rq, 32'h0000FF00, "unmapped write ignored");
    endtask : t_fields
    task automatic t_fault;
        logic [15:0] c [5] = '{16'h0018, 16'h0010, 16'h0010, 16'h0018, 16'h0000};
        logic        al [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        foreach (c[i])
        begin
            alarm_event <= al[i];
            wr_ctrl(c[i], 4'hF);
            repeat (4) @(posedge clock);
            #1;
            if (c[i][4])
                chk({30'h0, fault_oe, fault_o}, {30'h0, 1'b1, ~(al[i] ^ c[i][3])}, "fault pin");
            else
                chk({31'h0, fault_oe}, 32'h0, "fault released");
        end
    endtask : t_fault
    task automatic t_sync;
        int n_ptr, n_div;
        for (int en = 1; en >= 0; en--)
        begin
            wr_ctrl(en ? 16'h0004 : 16'h0000, 4'hF);
            n_ptr = 0;
            n_div = 0;
            @(posedge clock);
            sync_pin <= 1'b1;
            repeat (8)
            begin
                @(posedge clock);
                #1;
                n_ptr += (fifo_ptr_sync === 1'b1);
                n_div += (clkdiv_align === 1'b1);
            end
            sync_pin <= 1'b0;
            repeat (4) @(posedge clock);
            chk(n_ptr, en, "pointer sync pulses");
            chk(n_div, en, "divider align pulses");
        end
        bus(1'b0, DDC_STAT_OFS, 32'h0, 4'hF, rq);
        chk(rq & 32'h0000FF01, 32'h00000101, "sync count and alarm");
    endtask : t_sync
    initial
    begin
        {read, write, alarm_event, sync_pin} = 4'h0;
        address = 4'h0;
        byteenable = 4'hF;
        writedata = 32'h0;
        errors = 0;
        checks_done = 0;
        cyc = 0;
        arst_n = 1'b0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        t_reset();
        t_fields();
        t_fault();
        t_sync();
        tally_and_finish();
    end
endmodule : tb
